// ### pmt_pkg.sv
/*
 pmt_pkg: constants, register map and types for the period match timer.
 assumes one 20 MHz clock that stands for the instruction clock, and an AHB-Lite master.
*/
// Functional notes
// - timer runs only on instruction clock
// - count starts at zero, increments each tick
// - prescaler: pass, divide four, divide sixteen
// - compare count with period each tick
// - match returns count to zero next
// - postscaler ratio one to sixteen
// - postscaler completion sets latched match flag
// - interrupt only when flag and enable
// - count and period always read/writable
// - reset: count zero, period all ones
// - count or control write clears dividers
// - every device reset clears dividers
// - raw match drives pwm time base
// - match selectable as serial shift clock
// - sleep halts timer, keeps contents
`default_nettype none
package pmt_pkg;
   localparam logic [7:0] PMT_ADDR_COUNT   = 8'h00;
   localparam logic [7:0] PMT_ADDR_PERIOD  = 8'h04;
   localparam logic [7:0] PMT_ADDR_CONTROL = 8'h08;
   localparam logic [7:0] PMT_ADDR_FLAG    = 8'h0c;
   localparam logic [7:0] PMT_ADDR_CLEAR   = 8'h10;
   localparam logic [7:0] PMT_ADDR_ENABLE  = 8'h14;
   localparam logic [7:0] PMT_COUNT_RST    = 8'h00;
   localparam logic [7:0] PMT_PERIOD_RST   = 8'hff;
   localparam logic [7:0] PMT_CONTROL_RST  = 8'h00;
   localparam int PMT_PRE_LSB  = 0;
   localparam int PMT_ON_BIT   = 2;
   localparam int PMT_POST_LSB = 3;
   localparam int PMT_SPI_BIT  = 7;
   localparam int PMT_FLAG_BIT = 0;
   localparam logic [3:0] PMT_PRE_DIV4  = 4'h3;
   localparam logic [3:0] PMT_PRE_DIV16 = 4'hf;
   localparam logic [1:0] PMT_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] PMT_HTRANS_SEQ    = 2'h3;

   typedef enum logic [0:0] {
      PMT_IDLE = 1'b0,
      PMT_DATA = 1'b1
   } pmt_phase_t;

   typedef struct packed {
      pmt_phase_t  phase;
      logic        wr;
      logic [7:0]  addr;
      logic [7:0]  count;
      logic [7:0]  period;
      logic [7:0]  control;
      logic [3:0]  pre_cnt;
      logic [3:0]  post_cnt;
      logic        flag;
      logic        enable;
      logic        match;
      logic [31:0] rdata;
   } pmt_state_t;

   typedef struct packed {
      logic match_raw;
      logic serial_clk;
   } pmt_out_t;
endpackage : pmt_pkg
`default_nettype wire

// ### pmt_timer.sv
/*
 pmt_timer: 8-bit period match timer with prescaler, postscaler and ahb-lite slave.
 assumes MCLK is the instruction clock; SLEEP and the reset sources are
 synchronous to it (from core logic); RST is the power-on reset.
*/
`timescale 1ns/1ns
`default_nettype none
module pmt_timer
   import pmt_pkg::*;
(
   input  wire  logic        MCLK,
   input  wire  logic        RST,
   input  wire  logic        SOFT_RESET,
   input  wire  logic        SLEEP,
   input  wire  logic        HSEL,
   input  wire  logic [31:0] HADDR,
   input  wire  logic [1:0]  HTRANS,
   input  wire  logic        HWRITE,
   input  wire  logic [2:0]  HSIZE,
   input  wire  logic [31:0] HWDATA,
   input  wire  logic        HREADY,
   output logic [31:0]       HRDATA,
   output logic              HREADYOUT,
   output logic              HRESP,
   output logic              IRQ,
   output pmt_out_t          TIMER_OUT
);
   pmt_state_t s_q;
   pmt_state_t s_d;
   logic       ahb_go;
   logic       wr_count;
   logic       wr_ctrl;
   logic       tick;
   logic [3:0] pre_top;
   logic       post_done;

   function automatic logic [3:0] pre_limit(input logic [1:0] sel);
      case (sel)
         2'b00:   pre_limit = 4'h0;
         2'b01:   pre_limit = PMT_PRE_DIV4;
         default: pre_limit = PMT_PRE_DIV16;
      endcase
   endfunction : pre_limit

   assign ahb_go   = HSEL && HREADY && (HTRANS == PMT_HTRANS_NONSEQ || HTRANS == PMT_HTRANS_SEQ);
   assign wr_count = s_q.phase == PMT_DATA && s_q.wr && s_q.addr == PMT_ADDR_COUNT;
   assign wr_ctrl  = s_q.phase == PMT_DATA && s_q.wr && s_q.addr == PMT_ADDR_CONTROL;
   assign pre_top  = pre_limit(s_q.control[PMT_PRE_LSB +: 2]);
   // counting stops in sleep; registers keep their values
   assign tick     = s_q.control[PMT_ON_BIT] && !SLEEP && s_q.pre_cnt == pre_top;
   // postscaler completes this cycle, even when the flag is already set
   assign post_done = tick && s_q.count == s_q.period
                      && s_q.post_cnt == s_q.control[PMT_POST_LSB +: 4];

   always_comb begin
      s_d       = s_q;
      s_d.match = 1'b0;
      // prescaler
      if (s_q.control[PMT_ON_BIT] && !SLEEP) begin
         s_d.pre_cnt = tick ? 4'h0 : s_q.pre_cnt + 4'h1;
      end
      // counter and comparator
      if (tick) begin
         if (s_q.count == s_q.period) begin
            s_d.count = PMT_COUNT_RST;
            s_d.match = 1'b1;
            if (s_q.post_cnt == s_q.control[PMT_POST_LSB +: 4]) begin
               s_d.post_cnt = 4'h0;
               s_d.flag     = 1'b1;
            end else begin
               s_d.post_cnt = s_q.post_cnt + 4'h1;
            end
         end else begin
            s_d.count = s_q.count + 8'h01;
         end
      end
      // bus data phase: writes land here, one cycle after the address
      if (s_q.phase == PMT_DATA && s_q.wr) begin
         case (s_q.addr)
            PMT_ADDR_COUNT:   s_d.count   = HWDATA[7:0];
            PMT_ADDR_PERIOD:  s_d.period  = HWDATA[7:0];
            PMT_ADDR_CONTROL: s_d.control = HWDATA[7:0];
            PMT_ADDR_CLEAR: begin
               // a postscaler completion in the same cycle wins over the clear
               if (HWDATA[PMT_FLAG_BIT] && !post_done) begin
                  s_d.flag = 1'b0;
               end
            end
            PMT_ADDR_ENABLE:  s_d.enable  = HWDATA[PMT_FLAG_BIT];
            default: ;
         endcase
      end
      if (wr_count || wr_ctrl || SOFT_RESET) begin
         s_d.pre_cnt  = 4'h0;
         s_d.post_cnt = 4'h0;
      end
      if (SOFT_RESET) begin
         s_d.count   = PMT_COUNT_RST;
         s_d.period  = PMT_PERIOD_RST;
         s_d.control = PMT_CONTROL_RST;
         s_d.flag    = 1'b0;
         s_d.enable  = 1'b0;
         s_d.match   = 1'b0;
      end
      // address phase capture and read data
      s_d.phase = ahb_go ? PMT_DATA : PMT_IDLE;
      s_d.wr    = ahb_go && HWRITE;
      s_d.addr  = ahb_go ? HADDR[7:0] : 8'h00;
      s_d.rdata = 32'h0000_0000;
      if (ahb_go && !HWRITE) begin
         case (HADDR[7:0])
            PMT_ADDR_COUNT:   s_d.rdata = {24'h000000, s_q.count};
            PMT_ADDR_PERIOD:  s_d.rdata = {24'h000000, s_q.period};
            PMT_ADDR_CONTROL: s_d.rdata = {24'h000000, s_q.control};
            PMT_ADDR_FLAG:    s_d.rdata = {31'h0, s_q.flag};
            PMT_ADDR_ENABLE:  s_d.rdata = {31'h0, s_q.enable};
            default:          s_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         s_q         <= '0;
         s_q.phase   <= PMT_IDLE;
         s_q.count   <= PMT_COUNT_RST;
         s_q.period  <= PMT_PERIOD_RST;
         s_q.control <= PMT_CONTROL_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // zero wait states; hsize ignored, word access assumed
   assign HRDATA    = s_q.rdata;
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;
   assign IRQ       = s_q.flag && s_q.enable;
   assign TIMER_OUT.match_raw  = s_q.match;
   // gated so the serial port sees no stray edges when not selected
   assign TIMER_OUT.serial_clk = s_q.match && s_q.control[PMT_SPI_BIT];
endmodule : pmt_timer
`default_nettype wire

// ### pmt_timer_properties.sv
/* pmt_chk: port assertions for pmt_timer; assumes one MCLK domain, RST active high. */
`timescale 1ns/1ns
`default_nettype none
module pmt_chk import pmt_pkg::*; (
   input wire logic        MCLK,
   input wire logic        RST,
   input wire logic        SOFT_RESET,
   input wire logic        SLEEP,
   input wire logic        HSEL,
   input wire logic        HWRITE,
   input wire logic        HREADY,
   input wire logic        HREADYOUT,
   input wire logic        HRESP,
   input wire logic        IRQ,
   input wire logic [31:0] HADDR,
   input wire logic [31:0] HRDATA,
   input wire logic [1:0]  HTRANS,
   input wire pmt_out_t    TIMER_OUT
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   wire logic rd = HSEL && HREADY && HTRANS[1] && !HWRITE;
   property p_rdy; HREADYOUT; endproperty
   a_rdy: assert property (p_rdy) else $error("ready low");
   property p_rsp; !HRESP; endproperty
   a_rsp: assert property (p_rsp) else $error("response not okay");
   property p_ser; TIMER_OUT.serial_clk |-> TIMER_OUT.match_raw; endproperty
   a_ser: assert property (p_ser) else $error("shift clock without match");
   property p_slp; SLEEP [*3] |-> !TIMER_OUT.match_raw; endproperty
   a_slp: assert property (p_slp) else $error("match in sleep");
   // a device reset may still clear the flag while asleep
   property p_irs; (SLEEP && !HSEL && !SOFT_RESET) [*3] |-> $stable(IRQ); endproperty
   a_irs: assert property (p_irs) else $error("irq moved in sleep");
   property p_srs; SOFT_RESET |=> !IRQ && !TIMER_OUT.match_raw; endproperty
   a_srs: assert property (p_srs) else $error("soft reset ignored");
   property p_hi; rd |=> HRDATA[31:8] == 24'h0; endproperty
   a_hi: assert property (p_hi) else $error("upper read bits set");
   property p_idl; !rd |=> HRDATA == 32'h0; endproperty
   a_idl: assert property (p_idl) else $error("read data outside read");
   property p_urd; rd && HADDR[7:0] > 8'h14 |=> HRDATA == 32'h0; endproperty
   a_urd: assert property (p_urd) else $error("unmapped read not zero");
   c_mat: cover property (TIMER_OUT.match_raw);
   c_irq: cover property ($rose(IRQ));
   c_ser: cover property (TIMER_OUT.serial_clk);
endmodule : pmt_chk
bind pmt_timer pmt_chk chk_u (.MCLK(MCLK), .RST(RST), .SOFT_RESET(SOFT_RESET), .SLEEP(SLEEP),
   .HSEL(HSEL), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
   .IRQ(IRQ), .HADDR(HADDR), .HRDATA(HRDATA), .HTRANS(HTRANS), .TIMER_OUT(TIMER_OUT));
`default_nettype wire

// ### pmt_pwm_model.sv
/* pmt_pwm_model: pwm time-base user, gap_q = cycles between raw matches; assumes mclk. */
`timescale 1ns/1ns
`default_nettype none
module pmt_pwm_model import pmt_pkg::*; (
   input  wire logic     mclk,
   input  wire pmt_out_t tout,
   output logic [15:0]   gap_q
);
   logic [15:0] run_q;
   always_ff @(posedge mclk) begin
      run_q <= tout.match_raw ? 16'h1 : run_q + 16'h1;
      if (tout.match_raw) gap_q <= run_q;
   end
endmodule : pmt_pwm_model
`default_nettype wire

// ### testbench.sv
/* testbench: random period and postscale runs of pmt_timer at each prescale setting over ahb-lite;
   assumes pmt_pkg, pmt_pwm_model and the bound pmt_chk. */
`timescale 1ns/1ns
`default_nettype none
module testbench import pmt_pkg::*;;
   logic        mclk = 1'h0, rst = 1'h1, srst = 1'h0, slp = 1'h0, hsel = 1'h0, hwr = 1'h0;
   logic        rdy, irq;
   logic [1:0]  htr = 2'h0;
   logic [31:0] ha = 32'h0, hwd = 32'h0, hrd;
   logic [15:0] gap;
   pmt_out_t    tout;
   int          err_count = 0, checks = 0, cyc = 0, i, k, p, n, s;
   pmt_timer dut_u (.MCLK(mclk), .RST(rst), .SOFT_RESET(srst), .SLEEP(slp), .HSEL(hsel),
      .HADDR(ha), .HTRANS(htr), .HWRITE(hwr), .HSIZE(3'h2), .HWDATA(hwd), .HREADY(rdy),
      .HRDATA(hrd), .HREADYOUT(rdy), .HRESP(), .IRQ(irq), .TIMER_OUT(tout));
   pmt_pwm_model pwm_u (.mclk(mclk), .tout(tout), .gap_q(gap));
   always #25 mclk = ~mclk;
   always @(posedge mclk) if (++cyc == 30000) stop_test(1);
   task automatic stop_test(input int hung);
      err_count += hung;
      $display("err_count %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      err_count += int'(got !== exp);
      if (got !== exp) $display("MISMATCH %0t got %h exp %h", $time, got, exp);
   endtask : chk
   // reads compare at the data-phase edge, before that edge's own updates land
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      {hsel, htr, ha, hwr} <= {1'h1, PMT_HTRANS_NONSEQ, 24'h0, a, w};
      do @(posedge mclk); while (rdy !== 1'h1);
      {hsel, htr, hwd} <= {1'h0, 2'h0, d};
      do @(posedge mclk); while (rdy !== 1'h1);
      if (!w) chk(hrd, d);
   endtask : bus
   initial begin
      p = $urandom(10257);
      repeat (5) @(posedge mclk);
      rst <= 1'h0;
      bus(1'h0, PMT_ADDR_COUNT, 32'h0);
      bus(1'h0, PMT_ADDR_PERIOD, 32'hff);
      bus(1'h0, 8'h18, 32'h0);
      bus(1'h1, PMT_ADDR_ENABLE, 32'h1);
      for (i = 0; i < 4; i++) begin
         p = 1 + $urandom % 6;
         n = (i == 3) ? 15 : 1 + $urandom % 14;
         bus(1'h1, PMT_ADDR_CLEAR, 32'h1);
         bus(1'h1, PMT_ADDR_PERIOD, 32'(p));
         bus(1'h1, PMT_ADDR_COUNT, 32'h0);
         bus(1'h1, PMT_ADDR_CONTROL, 32'h84 + 32'(n * 8 + i));
         k = 0;
         s = 0;
         // sample 1 ns late so registered outputs have settled
         while (irq !== 1'h1) begin
            @(posedge mclk) #1;
            k += int'(tout.match_raw);
            s += int'(tout.serial_clk);
         end
         chk(32'(k), 32'(n + 1));
         chk(32'(s), 32'(n + 1));
         @(posedge mclk) #1;
         chk(32'(gap), 32'((p + 1) << (i == 0 ? 0 : i == 1 ? 2 : 4)));
         bus(1'h1, PMT_ADDR_CONTROL, 32'h0);
      end
      bus(1'h1, PMT_ADDR_ENABLE, 32'h0);
      bus(1'h0, PMT_ADDR_FLAG, 32'h1);
      chk(32'(irq), 32'h0);
      bus(1'h1, PMT_ADDR_CLEAR, 32'h1);
      bus(1'h0, PMT_ADDR_FLAG, 32'h0);
      bus(1'h1, PMT_ADDR_CONTROL, 32'h4);
      @(posedge mclk) slp <= 1'h1;
      bus(1'h1, PMT_ADDR_COUNT, 32'h5);
      repeat (4) @(posedge mclk);
      bus(1'h0, PMT_ADDR_COUNT, 32'h5);
      @(posedge mclk) slp <= 1'h0;
      @(posedge mclk) srst <= 1'h1;
      @(posedge mclk) srst <= 1'h0;
      bus(1'h0, PMT_ADDR_COUNT, 32'h0);
      bus(1'h0, PMT_ADDR_PERIOD, 32'hff);
      bus(1'h1, PMT_ADDR_PERIOD, 32'h5a);
      @(posedge mclk) rst <= 1'h1;
      @(posedge mclk) rst <= 1'h0;
      bus(1'h0, PMT_ADDR_PERIOD, 32'hff);
      stop_test(0);
   end
endmodule : testbench
`default_nettype wire
